/* pcpr_pkg.sv */
/*
 * Shared constants and types for the parallel configuration memory
 * read-out block: register map, field positions, timing counts, pin
 * indices and the packed state records.
 * Assumes a 25 MHz system clock and a 32-bit classic Wishbone master.
 */
`default_nettype none
package pcpr_pkg;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_ADDR = 8'h08;
	localparam logic [7:0] REG_LAST = 8'h0C;
	localparam logic [7:0] REG_MPTR = 8'h10;
	localparam logic [7:0] REG_MDATA = 8'h14;

	// control field positions
	localparam int CTRL_REV_LSB = 0;
	localparam int CTRL_CMD_BIT = 2;
	localparam int CTRL_CLKEN_BIT = 3;

	// reset values
	localparam logic [1:0] RST_INT_REV = 2'h0;
	localparam logic RST_CLK_EN = 1'b0;
	localparam logic [5:0] RST_LAST = 6'h3F;

	// storage shape: four revisions of 64 bytes
	localparam int CNT_W = 6;
	localparam int MEM_DEPTH = 256;

	// timing
	localparam int CLK_NS = 40;
	localparam int PULSE_MIN_NS = 300;
	localparam int PULSE_MAX_NS = 500;
	localparam int PULSE_CYC = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int CLOCK_OUTPUT_HALF_NS = 80;
	localparam int CLOCK_OUTPUT_HALF_CYC = CLOCK_OUTPUT_HALF_NS / CLK_NS;

	// synchronised pin indices
	localparam int SYNC_W = 8;
	localparam int PIN_CONFIG_CLOCK = 0;
	localparam int PIN_BUSY = 1;
	localparam int PIN_OERST_N = 2;
	localparam int PIN_CE_N = 3;
	localparam int PIN_CF_N = 4;
	localparam int PIN_EXT_EN = 5;
	localparam int PIN_REV_LSB = 6;

	typedef enum logic [1:0] {
		PST_IDLE = 2'h0,
		PST_SAMPLE = 2'h1,
		PST_PULSE = 2'h3
	} pcpr_pst_t;

	typedef struct packed {
		logic [SYNC_W-1:0] meta;
		logic [SYNC_W-1:0] lvl;
		logic [SYNC_W-1:0] old;
	} pcpr_sync_t;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic done;
		logic [7:0] data;
		logic data_oe;
		logic ceo_n;
		logic [1:0] rev;
		logic [1:0] int_rev;
		logic clk_en;
		logic [CNT_W-1:0] last;
		logic [7:0] wptr;
		pcpr_pst_t pst;
		logic [3:0] pcnt;
		logic cf_oe;
		logic [1:0] dcnt;
		logic clock_output;
		logic ack;
		logic [31:0] rdat;
	} pcpr_state_t;
endpackage
`default_nettype wire

/* pcpr_sync.sv */
/*
 * Two-flop synchroniser with rising-edge detect for the block's pins.
 * Assumes every input is asynchronous to clk_i; edges are taken from
 * the second and third flops only.
 */
`timescale 1ns/1ps
`default_nettype none
module pcpr_sync
	import pcpr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [SYNC_W-1:0] async_i,
	output logic [SYNC_W-1:0] level_o,
	output logic [SYNC_W-1:0] rise_o
);
	pcpr_sync_t s_q;
	pcpr_sync_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.meta = async_i;
		s_d.lvl = s_q.meta;
		s_d.old = s_q.lvl;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// idle high so no pin shows a false rise on leaving reset
			s_q <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	assign level_o = s_q.lvl;

	for (genvar i = 0; i < SYNC_W; i++) begin : g_edge
		assign rise_o[i] = s_q.lvl[i] & ~s_q.old[i];
	end
endmodule
`default_nettype wire

/* pcpr_top.sv */
/*
 * Read-out side of a parallel configuration memory: byte stream on the
 * data pins, busy hold, counter reset, cascade enable, configuration
 * pulse with revision sampling, clock output, Wishbone register slave.
 * Assumes all pins are asynchronous to clk_i (25 MHz) and that the
 * configuration clock is at least eight system clocks long.
 */
// Contract
// - one byte per configuration clock rise, counter steps on each valid rise.
// - while busy is high, hold the byte and delay the next step.
// - target chip select and write must be held low externally.
// - output_enable_reset_n low resets the counter to zero.
// - chip_enable_n low keeps data outputs driven.
// - cascade_enable_out_n feeds next memory; clock and data shared.
// - after last byte, drive cascade_enable_out_n low and float data.
// - enable low makes data outputs drive at once, from own counter.
// - counter resets on output_enable_reset_n low or chip_enable_n high.
// - load-target command pulses config_pulse_n low once, 300 to 500 ns.
// - revision latched on config_pulse_n rise, from pins or internal bits.
// - load-target command samples the revision before pulsing.
// - target clock comes from clock_output or an outside source.
// - configuration starts at power up, by program pulse, or command.
// - when reset or disabled, cascade out high and other outputs float; clock_output_o has no enable and stays driven, and config_pulse_n_o ignores disable.
`timescale 1ns/1ps
`default_nettype none
module pcpr_top
	import pcpr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic config_clock_i,
	input wire logic busy_i,
	input wire logic output_enable_reset_n_i,
	input wire logic chip_enable_n_i,
	input wire logic [1:0] revision_select_i,
	input wire logic external_revision_enable_i,
	input wire logic config_pulse_n_i,
	output logic config_pulse_n_o,
	output logic config_pulse_n_oe_o,
	output logic [7:0] data_byte_o,
	output logic data_byte_oe_o,
	output logic cascade_enable_out_n_o,
	output logic clock_output_o
);
	pcpr_state_t s_q;
	pcpr_state_t s_d;
	logic [7:0] mem_q [0:MEM_DEPTH-1];
	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] pin_lvl;
	logic [SYNC_W-1:0] pin_rise;
	logic [7:0] mem_rd;
	logic [31:0] rd_word;
	logic req;
	logic wr;
	logic enabled;
	logic step;
	logic [1:0] rev_src;

	assign pin_raw = {revision_select_i,
		external_revision_enable_i,
		config_pulse_n_i,
		chip_enable_n_i,
		output_enable_reset_n_i,
		busy_i,
		config_clock_i};

	pcpr_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(pin_raw),
		.level_o(pin_lvl),
		.rise_o(pin_rise)
	);

	// each revision owns its own 64-byte window
	assign mem_rd = mem_q[{s_q.rev, s_q.cnt}];

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (wb_adr_i)
			REG_CTRL: begin
				rd_word[CTRL_REV_LSB +: 2] = s_q.int_rev;
				rd_word[CTRL_CLKEN_BIT] = s_q.clk_en;
			end
			REG_STATUS: begin
				rd_word[1:0] = s_q.rev;
				rd_word[2] = s_q.data_oe;
				rd_word[3] = s_q.ceo_n;
				rd_word[4] = s_q.done;
				rd_word[5] = (s_q.pst != PST_IDLE);
				rd_word[6] = pin_lvl[PIN_BUSY];
			end
			REG_ADDR: begin
				rd_word[CNT_W-1:0] = s_q.cnt;
			end
			REG_LAST: begin
				rd_word[CNT_W-1:0] = s_q.last;
			end
			REG_MPTR: begin
				rd_word[7:0] = s_q.wptr;
			end
			REG_MDATA: begin
				rd_word[7:0] = mem_q[s_q.wptr];
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		s_d = s_q;
		req = wb_cyc_i & wb_stb_i;
		// a write lands on the edge where the master sees ack
		wr = req & wb_we_i & s_q.ack & wb_sel_i[0];
		enabled = pin_lvl[PIN_OERST_N] & ~pin_lvl[PIN_CE_N];
		step = pin_rise[PIN_CONFIG_CLOCK] & ~pin_lvl[PIN_BUSY];
		if (pin_lvl[PIN_EXT_EN]) begin
			rev_src = pin_lvl[PIN_REV_LSB +: 2];
		end else begin
			rev_src = s_q.int_rev;
		end

		// bus slave: one wait state, ack for one cycle
		s_d.ack = req & ~s_q.ack;
		if (req & ~s_q.ack) begin
			s_d.rdat = rd_word;
		end
		if (wr) begin
			unique case (wb_adr_i)
				REG_CTRL: begin
					s_d.int_rev = wb_dat_i[CTRL_REV_LSB +: 2];
					s_d.clk_en = wb_dat_i[CTRL_CLKEN_BIT];
				end
				REG_LAST: begin
					s_d.last = wb_dat_i[CNT_W-1:0];
				end
				REG_MPTR: begin
					s_d.wptr = wb_dat_i[7:0];
				end
				REG_MDATA: begin
					s_d.wptr = s_q.wptr + 8'h01;
				end
				default: begin
					s_d.last = s_q.last;
				end
			endcase
		end

		// byte stream toward the target
		if (!enabled) begin
			s_d.cnt = '0;
			s_d.done = 1'b0;
			s_d.data_oe = 1'b0;
			s_d.ceo_n = 1'b1;
		end else begin
			s_d.data = mem_rd;
			if (!s_q.done) begin
				s_d.data_oe = 1'b1;
			end
			// busy high freezes both the byte and the counter
			if (step && !s_q.done) begin
				if (s_q.cnt == s_q.last) begin
					s_d.done = 1'b1;
					s_d.data_oe = 1'b0;
					s_d.ceo_n = 1'b0;
				end else begin
					s_d.cnt = s_q.cnt + 1'b1;
				end
			end
		end

		// revision follows any release of the program line
		if (pin_rise[PIN_CF_N]) begin
			s_d.rev = rev_src;
		end

		// load-target pulse, started by a control register write
		unique case (s_q.pst)
			PST_IDLE: begin
				if (wr && wb_adr_i == REG_CTRL &&
					wb_dat_i[CTRL_CMD_BIT]) begin
					s_d.pst = PST_SAMPLE;
				end
			end
			PST_SAMPLE: begin
				s_d.rev = rev_src;
				s_d.pcnt = 4'(PULSE_CYC - 1);
				s_d.cf_oe = 1'b1;
				s_d.pst = PST_PULSE;
			end
			PST_PULSE: begin
				if (s_q.pcnt == 4'h0) begin
					s_d.cf_oe = 1'b0;
					s_d.pst = PST_IDLE;
				end else begin
					s_d.pcnt = s_q.pcnt - 4'h1;
				end
			end
			default: begin
				s_d.cf_oe = 1'b0;
				s_d.pst = PST_IDLE;
			end
		endcase

		// divided clock for targets without their own source
		if (s_q.clk_en) begin
			if (s_q.dcnt == 2'(CLOCK_OUTPUT_HALF_CYC - 1)) begin
				s_d.dcnt = 2'h0;
				s_d.clock_output = ~s_q.clock_output;
			end else begin
				s_d.dcnt = s_q.dcnt + 2'h1;
			end
		end else begin
			s_d.dcnt = 2'h0;
			s_d.clock_output = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.ceo_n <= 1'b1;
			s_q.int_rev <= RST_INT_REV;
			s_q.clk_en <= RST_CLK_EN;
			s_q.last <= RST_LAST;
			s_q.pst <= PST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// storage is not reset; software loads it before use
	always_ff @(posedge clk_i) begin
		if (wr && wb_adr_i == REG_MDATA) begin
			mem_q[s_q.wptr] <= wb_dat_i[7:0];
		end
	end

	assign wb_dat_o = s_q.rdat;
	assign wb_ack_o = s_q.ack;
	// open-drain: only ever pulls low
	assign config_pulse_n_o = 1'b0;
	assign config_pulse_n_oe_o = s_q.cf_oe;
	assign data_byte_o = s_q.data;
	assign data_byte_oe_o = s_q.data_oe;
	assign cascade_enable_out_n_o = s_q.ceo_n;
	assign clock_output_o = s_q.clock_output;
endmodule
`default_nettype wire

/* pcpr_props.sv */
/* Port checker for pcpr_top.
   Assumes pins change just after clk_i edges. */
`timescale 1ns/1ps
`default_nettype none
module pcpr_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_ack_o,
	input wire logic config_clock_i,
	input wire logic busy_i,
	input wire logic output_enable_reset_n_i,
	input wire logic chip_enable_n_i,
	input wire logic config_pulse_n_oe_o,
	input wire logic [7:0] data_byte_o,
	input wire logic data_byte_oe_o,
	input wire logic cascade_enable_out_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// six cycles cover the pin synchroniser lag
	AST_RST_FLOAT:
	assert property (!output_enable_reset_n_i[*6] |-> !data_byte_oe_o &&
		cascade_enable_out_n_o) else $error("reset left outputs on");
	AST_DIS_FLOAT:
	assert property (chip_enable_n_i[*6] |-> !data_byte_oe_o &&
		cascade_enable_out_n_o) else $error("disable left outputs on");
	AST_BUSY_HOLD:
	assert property ((busy_i && output_enable_reset_n_i && !chip_enable_n_i)[*6]
		|-> $stable(data_byte_o)) else $error("byte moved while busy");
	AST_PULSE_WIDTH:
	assert property ($rose(config_pulse_n_oe_o) |-> config_pulse_n_oe_o[*8]
		##1 !config_pulse_n_oe_o) else $error("pulse width wrong");
	AST_PULSE_CAUSE:
	assert property ($rose(config_pulse_n_oe_o) |-> $past(wb_ack_o) ||
		$past(wb_ack_o, 2) || $past(wb_ack_o, 3)) else $error("stray pulse");
	AST_CEO_LAST:
	assert property ($fell(cascade_enable_out_n_o) |-> !data_byte_oe_o &&
		$past(data_byte_oe_o)) else $error("cascade without float");
	AST_DRIVE_EN:
	assert property ((output_enable_reset_n_i && !chip_enable_n_i &&
		cascade_enable_out_n_o)[*8] |-> data_byte_oe_o) else $error("not driving");
	AST_IDLE_HOLD:
	assert property ((!config_clock_i)[*8] ##0 data_byte_oe_o &&
		$past(data_byte_oe_o) |-> $stable(data_byte_o)) else $error("step w/o clk");
	cover property ($fell(cascade_enable_out_n_o));
	cover property ($rose(config_pulse_n_oe_o));
	cover property (busy_i && data_byte_oe_o);
endmodule
bind pcpr_top pcpr_props u_props (.clk_i, .rst_i, .wb_ack_o, .config_clock_i,
	.busy_i, .output_enable_reset_n_i, .chip_enable_n_i, .config_pulse_n_oe_o,
	.data_byte_o, .data_byte_oe_o, .cascade_enable_out_n_o);
`default_nettype wire

/* pcpr_target.sv */
/* Target model: slave parallel load port with busy.
   Assumes run_i and stall_i change just after clk_i edges. */
`timescale 1ns/1ps
`default_nettype none
module pcpr_target (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic stall_i,
	input wire logic [7:0] data_i,
	input wire logic oe_i,
	output logic config_clock_o,
	output logic busy_o,
	output logic [7:0] last_o,
	output logic [7:0] count_o
);
	logic [2:0] ph_q;
	// clock stands low between frames
	assign config_clock_o = ph_q[2];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph_q <= 3'h0;
			busy_o <= 1'b0;
			last_o <= 8'h00;
			count_o <= 8'h00;
		end else begin
			if (run_i || ph_q != 3'h0) ph_q <= ph_q + 3'h1;
			// busy moves three cycles before a rise
			if (ph_q == 3'h0) busy_o <= stall_i;
			// select and write held low: each unstalled rise with oe_i high loads
			if (ph_q == 3'h3 && !busy_o && oe_i) begin
				last_o <= data_i;
				count_o <= count_o + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* pcpr_top_tb.sv */
/* Self-checking bench for pcpr_top.
   Assumes the pcpr_target model on the load port. */
`timescale 1ns/1ps
`default_nettype none
module pcpr_top_tb
	import pcpr_pkg::*;
;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, run = 1'b0;
	logic oe_rst_n = 1'b0, ce_n = 1'b1, ext_en = 1'b0, cf_drv = 1'b1;
	logic stall = 1'b0;
	logic [1:0] rev = 2'h0;
	logic [7:0] adr = 8'h00, data, last, count;
	logic [31:0] dat = 32'h0, rdat, wb_dat_o;
	logic wb_ack_o, config_clock, busy, cf_o, cf_oe, data_oe, ceo_n, clko;
	wire logic cf_n;
	int num_errors = 0, cmp_count = 0;
	assign cf_n = cf_drv & ~(cf_oe & ~cf_o);
	always #20 clk_i = ~clk_i;
	pcpr_top u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
		.wb_dat_o, .wb_ack_o, .config_clock_i(config_clock), .busy_i(busy),
		.output_enable_reset_n_i(oe_rst_n), .chip_enable_n_i(ce_n),
		.revision_select_i(rev), .external_revision_enable_i(ext_en),
		.config_pulse_n_i(cf_n), .config_pulse_n_o(cf_o),
		.config_pulse_n_oe_o(cf_oe), .data_byte_o(data),
		.data_byte_oe_o(data_oe), .cascade_enable_out_n_o(ceo_n),
		.clock_output_o(clko));
	pcpr_target u_tgt (.clk_i, .rst_i, .run_i(run), .stall_i(stall),
		.data_i(data), .oe_i(data_oe), .config_clock_o(config_clock), .busy_o(busy),
		.last_o(last), .count_o(count));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rdat = wb_dat_o;
		cyc <= 1'b0;
		if (n >= 20) num_errors++;
	endtask
	task automatic t_regs();
		wb(1'b0, REG_LAST, 32'h0);
		chk(rdat, 32'(RST_LAST));
		wb(1'b0, 8'h40, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b1, REG_LAST, 32'h3);
		wb(1'b1, REG_MPTR, 32'h0);
		for (int i = 0; i < 4; i++) wb(1'b1, REG_MDATA, 32'hA0 + i);
		$display("regs done");
	endtask
	task automatic t_stream();
		int n;
		oe_rst_n <= 1'b1;
		ce_n <= 1'b0;
		run <= 1'b1;
		for (n = 0; count !== 8'h02 && n < 200; n++) @(posedge clk_i);
		stall <= 1'b1;
		repeat (40) @(posedge clk_i);
		chk({count, data}, 16'h02A2);
		wb(1'b0, REG_ADDR, 32'h0);
		chk(rdat, 32'h2);
		stall <= 1'b0;
		for (n = 0; ceo_n !== 1'b0 && n < 200; n++) @(posedge clk_i);
		chk({count, last}, 16'h04A3);
		chk(data_oe, 1'b0);
		run <= 1'b0;
		$display("stream done");
	endtask
	task automatic t_reset();
		oe_rst_n <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk({data_oe, ceo_n}, 2'h1);
		wb(1'b0, REG_ADDR, 32'h0);
		chk(rdat, 32'h0);
		oe_rst_n <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk({data_oe, data}, 9'h1A0);
		ce_n <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk({data_oe, ceo_n}, 2'h1);
		$display("reset done");
	endtask
	task automatic t_pulse();
		int n;
		wb(1'b1, REG_CTRL, 32'h6);
		for (n = 0; cf_oe !== 1'b1 && n < 20; n++) @(posedge clk_i);
		for (n = 0; cf_oe === 1'b1 && n < 20; n++) @(posedge clk_i);
		chk(n, 8);
		wb(1'b0, REG_STATUS, 32'h0);
		chk(rdat[1:0], 2'h2);
		ext_en <= 1'b1;
		rev <= 2'h1;
		cf_drv <= 1'b0;
		repeat (4) @(posedge clk_i);
		cf_drv <= 1'b1;
		repeat (6) @(posedge clk_i);
		wb(1'b0, REG_STATUS, 32'h0);
		chk(rdat[1:0], 2'h1);
		wb(1'b1, REG_CTRL, 32'h8);
		for (n = 0; clko !== 1'b1 && n < 20; n++) @(posedge clk_i);
		for (n = 0; clko === 1'b1 && n < 20; n++) @(posedge clk_i);
		chk(n, CLOCK_OUTPUT_HALF_CYC);
		$display("pulse done");
	endtask
	task automatic final_report();
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_stream();
		t_reset();
		t_pulse();
		final_report();
	end
	initial begin
		#200000;
		num_errors++;
		final_report();
	end
endmodule
`default_nettype wire
